// ===== rf_path_decoder.sv
// rf_path_decoder: turns the path register into registered port enables
// assumes: code comes from logic on mclk; unlisted codes isolate all ports
`timescale 1ns/100ps
`default_nettype none

module rf_path_decoder (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // path register value
    input wire logic [6:0] code,
    // port enables
    output var rf_switch_pkg::rf_ports_t ports
);
    import rf_switch_pkg::*;

    rf_ports_t next_ports;

    ////////////////////////////////////////////////////////////////////////////
    // R05 isolation by default
    assign next_ports.rf_port_one = (code == CODE_PORT_ONE);     // R06 port one
    assign next_ports.rf_port_two = (code == CODE_PORT_TWO);     // R07 port two
    assign next_ports.rf_port_three = (code == CODE_PORT_THREE); // R08 port three
    assign next_ports.rf_port_four = (code == CODE_PORT_FOUR);   // R09 port four
    assign next_ports.rf_port_five = (code == CODE_PORT_FIVE);   // R10 port five
    assign next_ports.rf_port_six = (code == CODE_PORT_SIX);     // R11 port six

    ////////////////////////////////////////////////////////////////////////////
    // R05 all open at reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ports <= '0;
        end else begin
            ports <= next_ports;
        end
    end

endmodule // rf_path_decoder

`default_nettype wire

// ===== rf_switch_pkg.sv
// rf_switch_pkg: constants, frame layouts and states of the switch control slave
// assumes: shared by rf_switch_serial_slave and rf_path_decoder
`default_nettype none

package rf_switch_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // frame lengths in bus clocks
    localparam int CMD_LEN = 13;
    localparam int DATA_LEN = 9;
    localparam int CNT_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // register map and field positions
    localparam logic [4:0] PATH_REG_ADDR = 5'h00;
    localparam int SOFT_RESET_BIT = 7;
    localparam logic [1:0] KIND_WRITE = 2'b10;
    localparam logic [1:0] KIND_READ = 2'b11;
    localparam logic [6:0] PATH_RESET = 7'h00;

    ////////////////////////////////////////////////////////////////////////////
    // path select codes, bits 6..0 of the path register
    localparam logic [6:0] CODE_PORT_ONE = 7'h02;
    localparam logic [6:0] CODE_PORT_TWO = 7'h0a;
    localparam logic [6:0] CODE_PORT_THREE = 7'h0e;
    localparam logic [6:0] CODE_PORT_FOUR = 7'h0b;
    localparam logic [6:0] CODE_PORT_FIVE = 7'h01;
    localparam logic [6:0] CODE_PORT_SIX = 7'h09;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic [3:0] sa;
        logic reg0_flag;
        logic [1:0] kind;
        logic [4:0] addr;
    } cmd_frame_t;

    typedef struct packed {
        logic rf_port_six;
        logic rf_port_five;
        logic rf_port_four;
        logic rf_port_three;
        logic rf_port_two;
        logic rf_port_one;
    } rf_ports_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_TURN = 3'b011,
        ST_RDAT = 3'b010,
        ST_RPARK = 3'b110,
        ST_DATA = 3'b101
    } bus_state_t;

endpackage

`default_nettype wire

// ===== rf_switch_serial_asserts.sv
// rf_switch_serial_asserts: port checks of the serial switch slave
// assumes: bound to rf_switch_serial_slave, single mclk domain
`timescale 1ns/100ps
`default_nettype none

module rf_switch_serial_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // serial bus pins
    input wire logic sclk,
    input wire logic sdata_in,
    input wire logic sdata_out,
    input wire logic sdata_oe,
    // path register and ports
    input wire logic [6:0] antenna_path_select,
    input wire rf_switch_pkg::rf_ports_t rf_ports
);
    import rf_switch_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // code settled for two edges
    sequence held(logic [6:0] c);
        (antenna_path_select == c)[*2];
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    AST_PORT_ONE: assert property (held(CODE_PORT_ONE) |-> rf_ports == 6'h01)
        else $error("port one not selected");
    AST_PORT_TWO: assert property (held(CODE_PORT_TWO) |-> rf_ports == 6'h02)
        else $error("port two not selected");
    AST_PORT_THREE: assert property (held(CODE_PORT_THREE) |-> rf_ports == 6'h04)
        else $error("port three not selected");
    AST_PORT_FOUR: assert property (held(CODE_PORT_FOUR) |-> rf_ports == 6'h08)
        else $error("port four not selected");
    AST_PORT_FIVE: assert property (held(CODE_PORT_FIVE) |-> rf_ports == 6'h10)
        else $error("port five not selected");
    AST_PORT_SIX: assert property (held(CODE_PORT_SIX) |-> rf_ports == 6'h20)
        else $error("port six not selected");
    AST_ONE_PORT: assert property ($onehot0(rf_ports))
        else $error("more than one port connected");
    AST_RESET_ISOLATE: assert property (disable iff (1'b0) $rose(rst_n) |-> rf_ports == 6'h00 && antenna_path_select == 7'h00)
        else $error("not isolated after reset");
    AST_READ_KEEPS: assert property (sdata_oe |=> $stable(antenna_path_select))
        else $error("path changed during read");
    AST_PARK_LOW: assert property ($fell(sdata_oe) |-> $past(sdata_out) == 1'b0)
        else $error("read not parked low");
endmodule // rf_switch_serial_asserts

bind rf_switch_serial_slave rf_switch_serial_asserts chk_u (
    .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .sdata_in(sdata_in), .sdata_out(sdata_out),
    .sdata_oe(sdata_oe), .antenna_path_select(antenna_path_select), .rf_ports(rf_ports)
);

`default_nettype wire

// ===== rf_switch_serial_slave.sv
// rf_switch_serial_slave: two-wire serial control slave and path register
// assumes: sclk and sdata come from the bus master pins; sclk well under mclk/8
//
// Function
// R01: master opens each sequence with a start condition, then command, then data.
// R02: path write: address, one in bit 7, seven data bits, parity, park.
// R03: register write: address, 0, 10, 5-bit address, parity, data byte, parity, park.
// R04: register read: address, 0, 11, address, parity, park; device returns byte, parity, park.
// R05: reset leaves all ports isolated, path register zero.
// R06: code 0000010 connects port one.
// R07: code 0001010 connects port two.
// R08: code 0001110 connects port three.
// R09: code 0001011 connects port four.
// R10: code 0000001 connects port five.
// R11: code 0001001 connects port six.
// R12: bit 7 written set returns path register to default, slave ID kept.
// R13: only sequences addressed to own slave ID are acted on.
// R14: parity makes each frame odd; failing frames are discarded.
`timescale 1ns/100ps
`default_nettype none

module rf_switch_serial_slave #(
    parameter logic [3:0] SLAVE_ID = 4'h1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // serial bus pins
    input wire logic sclk,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe,
    // path register and port enables
    output logic [6:0] antenna_path_select,
    output var rf_switch_pkg::rf_ports_t rf_ports
);
    import rf_switch_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic odd_ok(input logic [12:0] v);
        return ^v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detect
    logic sclk_meta;
    logic sclk_sync;
    logic sclk_prev;
    logic sdata_meta;
    logic sdata_sync;
    logic sdata_prev;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_meta <= 1'b0;
            sclk_sync <= 1'b0;
            sclk_prev <= 1'b0;
            sdata_meta <= 1'b0;
            sdata_sync <= 1'b0;
            sdata_prev <= 1'b0;
        end else begin
            sclk_meta <= sclk;
            sclk_sync <= sclk_meta;
            sclk_prev <= sclk_sync;
            sdata_meta <= sdata_in;
            sdata_sync <= sdata_meta;
            sdata_prev <= sdata_sync;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic sdata_rise;
    logic sdata_fall;

    assign sclk_rise = sclk_sync & ~sclk_prev;
    assign sclk_fall = ~sclk_sync & sclk_prev;
    assign sdata_rise = sdata_sync & ~sdata_prev;
    assign sdata_fall = ~sdata_sync & sdata_prev;

    ////////////////////////////////////////////////////////////////////////////
    // start condition: data pulse while clock stays low
    logic ssc_armed;
    logic ssc;

    // R01 start detect
    assign ssc = ssc_armed & sdata_fall & ~sclk_sync & ~sdata_oe;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ssc_armed <= 1'b0;
        end else if (sclk_sync | sdata_oe) begin
            ssc_armed <= 1'b0;
        end else if (sdata_rise) begin
            ssc_armed <= 1'b1;
        end else if (sdata_fall) begin
            ssc_armed <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame shifter and decode
    bus_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [12:0] shreg;
    logic [12:0] next_shreg;
    cmd_frame_t cmd;
    logic cmd_done;
    logic data_done;
    logic cmd_ok;
    logic is_path_write;
    logic is_write;
    logic is_read;
    logic addr_hit;
    logic target_hit;
    logic data_ok;
    logic [7:0] wdata;

    assign next_shreg = {shreg[11:0], sdata_sync};
    assign cmd = cmd_frame_t'(next_shreg[12:1]);
    assign cmd_done = (state == ST_CMD) && sclk_fall && (cnt == CNT_W'(CMD_LEN - 1));
    assign data_done = (state == ST_DATA) && sclk_fall && (cnt == CNT_W'(DATA_LEN - 1));
    // R13 own slave ID
    // R14 command parity
    assign cmd_ok = odd_ok(next_shreg) && (cmd.sa == SLAVE_ID);
    // R02 path write frame
    assign is_path_write = cmd.reg0_flag;
    // R03 write frame
    assign is_write = ~cmd.reg0_flag && (cmd.kind == KIND_WRITE);
    // R04 read frame
    assign is_read = ~cmd.reg0_flag && (cmd.kind == KIND_READ);
    assign addr_hit = (cmd.addr == PATH_REG_ADDR);
    // R14 data parity
    assign data_ok = odd_ok({4'h0, next_shreg[8:0]});
    assign wdata = next_shreg[8:1];

    ////////////////////////////////////////////////////////////////////////////
    // path register
    logic path_write;
    logic [6:0] next_path;

    assign path_write = (cmd_done && cmd_ok && is_path_write) || (data_done && data_ok && target_hit);

    // R02 seven-bit write
    // R12 soft reset bit
    assign next_path = cmd_done ? next_shreg[7:1] : (wdata[SOFT_RESET_BIT] ? PATH_RESET : wdata[6:0]);

    // R05 reset isolation
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            antenna_path_select <= PATH_RESET;
        end else if (path_write) begin
            antenna_path_select <= next_path;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read word: zero soft reset bit, path bits, odd parity
    logic [8:0] rd_word;
    logic [8:0] rd_shreg;

    // R14 read parity
    assign rd_word = {1'b0, antenna_path_select, ~(^antenna_path_select)};

    ////////////////////////////////////////////////////////////////////////////
    // sequence state machine
    bus_state_t next_state;

    always_comb begin
        next_state = state;
        if (ssc) begin
            next_state = ST_CMD;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                ST_CMD: begin
                    if (cmd_done) begin
                        if (!cmd_ok || is_path_write) begin
                            next_state = ST_IDLE;
                        end else if (is_write) begin
                            next_state = ST_DATA;
                        end else if (is_read && addr_hit) begin
                            next_state = ST_TURN;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_DATA: begin
                    if (data_done) begin
                        next_state = ST_IDLE;
                    end
                end
                ST_TURN: begin
                    if (sclk_fall) begin
                        next_state = ST_RDAT;
                    end
                end
                ST_RDAT: begin
                    if (sclk_rise && (cnt == CNT_W'(DATA_LEN))) begin
                        next_state = ST_RPARK;
                    end
                end
                ST_RPARK: begin
                    if (sclk_fall) begin
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit counter and shifters
    logic shift_in;
    logic shift_out;

    assign shift_in = sclk_fall && ((state == ST_CMD) || (state == ST_DATA));
    assign shift_out = sclk_rise && (state == ST_RDAT) && (cnt != CNT_W'(DATA_LEN));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (ssc || cmd_done || (state == ST_TURN)) begin
            cnt <= '0;
        end else if (shift_in || shift_out) begin
            cnt <= cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= '0;
        end else if (shift_in) begin
            shreg <= next_shreg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            target_hit <= 1'b0;
        end else if (cmd_done) begin
            target_hit <= addr_hit;
        end
    end

    // R04 read data out
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_shreg <= '0;
        end else if (cmd_done) begin
            rd_shreg <= rd_word;
        end else if (shift_out) begin
            rd_shreg <= {rd_shreg[7:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data pin drive: bits on rising edges, park low then release
    // R04 drive and park
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sdata_out <= 1'b0;
            sdata_oe <= 1'b0;
        end else if (shift_out) begin
            sdata_out <= rd_shreg[8];
            sdata_oe <= 1'b1;
        end else if ((state == ST_RDAT) && sclk_rise) begin
            sdata_out <= 1'b0;
            sdata_oe <= 1'b1;
        end else if ((state == ST_RPARK) && sclk_fall) begin
            sdata_out <= 1'b0;
            sdata_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port enables
    rf_path_decoder u_path_decoder (
        .mclk(mclk),
        .rst_n(rst_n),
        .code(antenna_path_select),
        .ports(rf_ports)
    );

endmodule // rf_switch_serial_slave

`default_nettype wire

// ===== rffe_bus_master_model.sv
// rffe_bus_master_model: two-wire bus master issuing command sequences
// assumes: drives on mclk falling edges, sclk period 10 mclk
`timescale 1ns/100ps
`default_nettype none

module rffe_bus_master_model (
    // clock
    input wire logic mclk,
    // bus pins
    output logic sclk,
    output logic sdata_drv,
    output logic sdata_en,
    input wire logic sdata_line
);
    initial begin
        sclk = 1'b0;
        sdata_drv = 1'b0;
        sdata_en = 1'b1;
    end

    task automatic half();
        repeat (5) @(negedge mclk);
    endtask

    // one bit, slave samples on the fall
    task automatic put_bit(input logic b);
        sclk = 1'b1;
        sdata_drv = b;
        half();
        sclk = 1'b0;
        half();
    endtask

    task automatic command(input logic [11:0] c, input logic flip);
        logic [12:0] w;
        w = {c, ~^c ^ flip};
        sdata_drv = 1'b1;
        half();
        sdata_drv = 1'b0;
        half();
        for (int i = 12; i >= 0; i--) put_bit(w[i]);
    endtask

    // path write, odd parity unless flipped
    task automatic reg0_write(input logic [3:0] sa, input logic [6:0] d, input logic flip);
        command({sa, 1'b1, d}, flip);
        put_bit(1'b0);
    endtask

    task automatic reg_write(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] d, input logic flip);
        logic [8:0] w;
        w = {d, ~^d ^ flip};
        command({sa, 1'b0, 2'b10, a}, 1'b0);
        for (int i = 8; i >= 0; i--) put_bit(w[i]);
        put_bit(1'b0);
    endtask

    // register read, released after the park cycle
    task automatic reg_read(input logic [3:0] sa, input logic [4:0] a, output logic [8:0] got);
        command({sa, 1'b0, 2'b11, a}, 1'b0);
        put_bit(1'b0);
        sdata_en = 1'b0;
        for (int i = 8; i >= 0; i--) begin
            sclk = 1'b1;
            half();
            sclk = 1'b0;
            got[i] = sdata_line;
            half();
        end
        put_bit(1'b0);
        sdata_en = 1'b1;
    endtask
endmodule // rffe_bus_master_model

`default_nettype wire

// ===== tb_top.sv
// tb_top: self-checking bench of the serial switch slave
// assumes: master model drives the bus, released line pulls low
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import rf_switch_pkg::*;
    localparam logic [3:0] OWN_ID = 4'h5;
    logic mclk, rst_n, sclk, m_drv, m_en, sdata_out, sdata_oe;
    logic [6:0] antenna_path_select;
    logic [8:0] got;
    rf_ports_t rf_ports;
    wire logic sdata_line;
    int fails = 0;
    int comparisons = 0;

    assign sdata_line = sdata_oe ? sdata_out : (m_en ? m_drv : 1'b0);

    rf_switch_serial_slave #(.SLAVE_ID(OWN_ID)) dut_u (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
        .sdata_in(sdata_line), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
        .antenna_path_select(antenna_path_select), .rf_ports(rf_ports));
    rffe_bus_master_model master_u (.mclk(mclk), .sclk(sclk), .sdata_drv(m_drv), .sdata_en(m_en),
        .sdata_line(sdata_line));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic test_reset();
        check("path", antenna_path_select, 7'h00);
        check("ports", rf_ports, 6'h00);
        check("oe", sdata_oe, 1'b0);
        $display("test reset done");
    endtask

    task automatic test_codes();
        logic [6:0] codes [6] = '{CODE_PORT_ONE, CODE_PORT_TWO, CODE_PORT_THREE,
                                  CODE_PORT_FOUR, CODE_PORT_FIVE, CODE_PORT_SIX};
        for (int i = 0; i < 6; i++) begin
            master_u.reg0_write(OWN_ID, codes[i], 1'b0);
            check("path", antenna_path_select, codes[i]);
            check("ports", rf_ports, 6'h01 << i);
        end
        master_u.reg0_write(OWN_ID, 7'h7f, 1'b0);
        check("ports", rf_ports, 6'h00);
        $display("test codes done");
    endtask

    task automatic test_reg_write_read();
        master_u.reg_write(OWN_ID, 5'h00, 8'h0b, 1'b0);
        check("path", antenna_path_select, 7'h0b);
        check("ports", rf_ports, 6'h08);
        master_u.reg_read(OWN_ID, 5'h00, got);
        check("read", got, {8'h0b, ~^8'h0b});
        master_u.reg_write(OWN_ID, 5'h00, 8'h8e, 1'b0);
        check("path", antenna_path_select, 7'h00);
        check("ports", rf_ports, 6'h00);
        $display("test reg write read done");
    endtask

    task automatic test_refuse();
        master_u.reg0_write(OWN_ID, CODE_PORT_FIVE, 1'b0);
        master_u.reg0_write(OWN_ID ^ 4'h1, CODE_PORT_THREE, 1'b0);
        check("path", antenna_path_select, CODE_PORT_FIVE);
        master_u.reg0_write(OWN_ID, CODE_PORT_THREE, 1'b1);
        check("path", antenna_path_select, CODE_PORT_FIVE);
        master_u.reg_write(OWN_ID, 5'h00, 8'h0e, 1'b1);
        check("path", antenna_path_select, CODE_PORT_FIVE);
        master_u.reg_write(OWN_ID, 5'h03, 8'h0e, 1'b0);
        check("ports", rf_ports, 6'h10);
        master_u.reg_read(OWN_ID, 5'h03, got);
        check("read", got, 9'h000);
        $display("test refuse done");
    endtask

    task automatic test_reset_mid();
        master_u.reg0_write(OWN_ID, CODE_PORT_TWO, 1'b0);
        rst_n = 1'b0;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check("path", antenna_path_select, 7'h00);
        check("ports", rf_ports, 6'h00);
        master_u.reg0_write(OWN_ID, CODE_PORT_SIX, 1'b0);
        check("ports", rf_ports, 6'h20);
        $display("test reset mid done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        test_reset();
        test_codes();
        test_reg_write_read();
        test_refuse();
        test_reset_mid();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        give_verdict();
    end
endmodule // tb_top

`default_nettype wire
